/* hdl/crt_core.v */
`timescale 1ns/10ps
`include "crt_map.vh"
module crt_core (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire [15:0] fetch_addr,
  output wire        interrupt_in_service_flag
);

  reg  [15:0] instruction_pointer_reg;
  reg  [15:0] instruction_pointer_next;
  reg  [7:0]  transfer_prefix_latch_reg;
  reg  [7:0]  transfer_prefix_latch_next;
  reg         service_reg;
  reg         service_next;
  reg  [15:0] data_pointer_reg;
  reg  [15:0] data_pointer_next;
  reg         conflict_reg;
  reg         conflict_next;
  reg  [15:0] last_word_reg;
  reg  [15:0] pop_data_reg;
  reg  [15:0] pop_data_next;
  reg  [15:0] xfer_val_reg;
  reg         xfer_stored_reg;
  reg  [5:0]  peek_sel_reg;
  reg  [15:0] dmem [0:`CRT_DMEM_WORDS-1];
  reg  [15:0] src_val;
  reg         src_wide;
  reg  [1:0]  src_kind;
  reg         stk_push;
  reg         stk_pop;
  reg  [15:0] stk_wdata;
  reg         dm_we;
  reg         special_wr;
  reg  [31:0] rd_mux;
  wire [15:0] slot_q [0:63];
  wire [15:0] xfer_val;
  wire [15:0] stk_top;
  wire [4:0]  stk_ptr;
  wire        wr_en;
  wire        exec_instr;
  wire        exec_stk;
  wire        stat_clr;
  wire        mapped;
  wire [15:0] iw;
  wire [3:0]  dst_mod;
  wire [4:0]  dst_idx;
  wire [3:0]  src_mod;
  wire [4:0]  src_idx;
  wire [1:0]  dst_kind;
  wire        dst_sys;
  wire        src_sys;
  wire        src_is_stk;
  wire        src_is_dmem;
  wire        dst_is_dmem;
  wire        data_blocked;
  wire [15:0] dmem_rd;
  wire        slot_we;
  wire [5:0]  slot_wsel;
  wire [63:0] slot_hit;
  wire [2:0]  op;
  wire [15:0] operand;
  wire [15:0] ip_inc;

  // Slot class: {defined, sixteen bits wide}
  function [1:0] slot_kind;
    input [3:0] m;
    input [4:0] i;
    begin
      case (m)
        `CRT_MOD_PER:
          slot_kind = {1'b1, ~i[4]};
        `CRT_MOD_SYS:
          if (i[4] || (i[3:0] == `CRT_IDX_HOLE))
            slot_kind = 2'b00;
          else if ((i[3:0] == `CRT_IDX_STKPTR) || (i[3:0] == `CRT_IDX_PREFIX)
                   || (i[3:0] == `CRT_IDX_SERVICE))
            slot_kind = 2'b10;
          else
            slot_kind = 2'b11;
        `CRT_MOD_ACC:
          slot_kind = {~i[4] & ~i[3], 1'b1};
        default:
          slot_kind = 2'b00;
      endcase
    end
  endfunction

  // Flat storage index of a slot
  function [5:0] slot_flat;
    input [3:0] m;
    input [4:0] i;
    begin
      if (m == `CRT_MOD_PER)
        slot_flat = {1'b0, i};
      else if (m == `CRT_MOD_SYS)
        slot_flat = {2'b10, i[3:0]};
      else
        slot_flat = {2'b11, i[3:0]};
    end
  endfunction

  // Instruction fields; prefix carries upper index bits
  assign iw          = pwdata[15:0];
  assign dst_mod     = iw[11:8];
  assign dst_idx     = {transfer_prefix_latch_reg[6:5], iw[14:12]};    // RULE23 RULE2
  assign src_mod     = iw[3:0];
  assign src_idx     = {transfer_prefix_latch_reg[4], iw[7:4]};        // RULE23 RULE1 RULE3
  assign dst_kind    = slot_kind(dst_mod, dst_idx);
  assign dst_sys     = (dst_mod == `CRT_MOD_SYS) && dst_kind[1];
  assign src_sys     = iw[15] && (src_mod == `CRT_MOD_SYS) && !src_idx[4];
  assign src_is_stk  = src_sys && (src_idx[3:0] == `CRT_IDX_STK);
  assign src_is_dmem = src_sys && (src_idx[3:0] == `CRT_IDX_DMEM);
  assign dst_is_dmem = dst_sys && (dst_idx[3:0] == `CRT_IDX_DMEM);
  assign op          = pwdata[2:0];
  assign operand     = pwdata[31:16];
  assign ip_inc      = instruction_pointer_reg + 16'h0001;

  // APB decode, zero wait states
  assign wr_en      = psel && penable && pwrite;
  assign exec_instr = wr_en && (paddr == `CRT_ADDR_INSTR);
  assign exec_stk   = wr_en && (paddr == `CRT_ADDR_STKOP);
  assign stat_clr   = wr_en && (paddr == `CRT_ADDR_STAT) && pwdata[`CRT_ST_CONFLICT];
  assign mapped     = (paddr == `CRT_ADDR_INSTR) || (paddr == `CRT_ADDR_STKOP)
                   || (paddr == `CRT_ADDR_STAT) || (paddr == `CRT_ADDR_IPTR)
                   || (paddr == `CRT_ADDR_DPTR) || (paddr == `CRT_ADDR_XFER)
                   || (paddr == `CRT_ADDR_PEEK);
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !mapped;

  // Working SRAM blocked while code runs from it
  assign data_blocked = (instruction_pointer_reg[15:11] == `CRT_SRAM_SEG); // RULE22
  assign dmem_rd      = data_blocked ? `CRT_UNDEF_WORD
                                     : dmem[data_pointer_reg[3:0]];     // RULE22

  // Storage slots, one per entry
  assign slot_we   = exec_instr && dst_kind[1] && ((dst_mod != `CRT_MOD_SYS)
                                                   || dst_idx[3]);      // RULE9 RULE4
  assign slot_wsel = slot_flat(dst_mod, dst_idx);
  assign slot_hit  = {63'h0, slot_we} << slot_wsel;

  genvar g;
  generate
    for (g = 0; g < 64; g = g + 1)
    begin : g_slot
      reg [15:0] q_reg;
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          q_reg <= 16'h0000;
        else if (slot_hit[g])
          q_reg <= xfer_val;                                           // RULE1 RULE2 RULE3
      end
      assign slot_q[g] = q_reg;
    end
  endgenerate

  // Source value and width
  always @*
  begin
    src_kind = slot_kind(src_mod, src_idx);
    src_wide = 1'b0;
    src_val  = 16'h0000;
    if (!iw[15])
      src_val = {8'h00, iw[7:0]};                                      // RULE23
    else if (!src_kind[1])
    begin
      src_wide = 1'b1;
      if ((src_mod == `CRT_MOD_PER) || (src_mod == `CRT_MOD_SYS))
        src_val = {transfer_prefix_latch_reg, `CRT_UNDEF_LOW};         // RULE10
      else
        src_val = `CRT_UNDEF_WORD;                                     // RULE11
    end
    else
    begin
      src_wide = src_kind[0];
      if (src_mod == `CRT_MOD_SYS)
      begin
        case (src_idx[3:0])
          `CRT_IDX_IPTR:    src_val = instruction_pointer_reg;
          `CRT_IDX_STKPTR:  src_val = {11'h000, stk_ptr};
          `CRT_IDX_STK:     src_val = stk_top;                          // RULE14
          `CRT_IDX_PREFIX:  src_val = {8'h00, transfer_prefix_latch_reg};
          `CRT_IDX_SERVICE: src_val = {15'h0000, service_reg};
          `CRT_IDX_DPTR:    src_val = data_pointer_reg;
          `CRT_IDX_DMEM:    src_val = dmem_rd;
          default:          src_val = slot_q[slot_flat(src_mod, src_idx)];
        endcase
      end
      else
        src_val = slot_q[slot_flat(src_mod, src_idx)];
    end
  end

  crt_width u_width (
    .src_val  (src_val),
    .src_wide (src_wide),
    .dst_wide (dst_kind[0]),
    .prefix   (transfer_prefix_latch_reg),
    .dst_val  (xfer_val)
  );

  crt_stack u_stack (
    .pclk          (pclk),
    .presetn       (presetn),
    .push          (stk_push),
    .pop           (stk_pop),
    .wdata         (stk_wdata),
    .rdata         (stk_top),
    .stack_pointer (stk_ptr)
  );

  // Next state of the core
  always @*
  begin
    instruction_pointer_next   = instruction_pointer_reg;
    transfer_prefix_latch_next = transfer_prefix_latch_reg;
    service_next               = service_reg;
    data_pointer_next          = data_pointer_reg;
    conflict_next              = conflict_reg && !stat_clr;
    pop_data_next              = pop_data_reg;
    stk_push                   = 1'b0;
    stk_pop                    = 1'b0;
    stk_wdata                  = 16'h0000;
    dm_we                      = 1'b0;
    special_wr                 = 1'b0;
    if (exec_instr)
    begin
      instruction_pointer_next   = ip_inc;                             // RULE21
      transfer_prefix_latch_next = 8'h00;                              // RULE8
      if (src_is_stk)
        stk_pop = 1'b1;                                                // RULE18
      if (src_is_dmem)
        data_pointer_next = data_pointer_reg - 16'h0001;               // RULE9
      if ((src_is_dmem || dst_is_dmem) && data_blocked)
        conflict_next = 1'b1;                                          // RULE22
      if (dst_sys)
      begin
        special_wr = !dst_idx[3];
        case (dst_idx[3:0])
          `CRT_IDX_IPTR:    instruction_pointer_next = xfer_val;       // RULE20
          `CRT_IDX_PREFIX:  transfer_prefix_latch_next = xfer_val[7:0]; // RULE23
          `CRT_IDX_SERVICE: service_next = xfer_val[0];
          `CRT_IDX_DPTR:    data_pointer_next = xfer_val;
          `CRT_IDX_DMEM:
          begin
            dm_we      = !data_blocked;                                // RULE22
            special_wr = 1'b0;
          end
          `CRT_IDX_STK:
          begin
            stk_push  = 1'b1;                                          // RULE17
            stk_wdata = xfer_val;
          end
          default:          special_wr = 1'b0;
        endcase
      end
    end
    if (exec_stk)
    begin
      transfer_prefix_latch_next = 8'h00;                              // RULE8
      case (op)
        `CRT_OP_CALL:
        begin
          stk_push                 = 1'b1;                             // RULE14 RULE17
          stk_wdata                = ip_inc;
          instruction_pointer_next = operand;
        end
        `CRT_OP_INT:
        begin
          stk_push                 = 1'b1;                             // RULE14 RULE17
          stk_wdata                = instruction_pointer_reg;
          instruction_pointer_next = operand;
          service_next             = 1'b1;
        end
        `CRT_OP_RET, `CRT_OP_RET_INT:
        begin
          stk_pop                  = 1'b1;                             // RULE14 RULE18
          instruction_pointer_next = stk_top;
        end
        `CRT_OP_PUSH:
        begin
          stk_push                 = 1'b1;                             // RULE17
          stk_wdata                = operand;
          instruction_pointer_next = ip_inc;
        end
        `CRT_OP_POP, `CRT_OP_POP_CLR:
        begin
          stk_pop                  = 1'b1;                             // RULE18
          pop_data_next            = stk_top;
          instruction_pointer_next = ip_inc;
          if (op == `CRT_OP_POP_CLR)
            service_next = 1'b0;                                       // RULE15
        end
        default:
          instruction_pointer_next = instruction_pointer_reg;
      endcase
    end
  end

  // Control registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      instruction_pointer_reg   <= `CRT_IPTR_RST;                      // RULE12
      transfer_prefix_latch_reg <= 8'h00;
      service_reg               <= 1'b0;
      data_pointer_reg          <= 16'h0000;
      conflict_reg              <= 1'b0;
      pop_data_reg              <= 16'h0000;
      last_word_reg             <= 16'h0000;
      xfer_val_reg              <= 16'h0000;
      xfer_stored_reg           <= 1'b0;
      peek_sel_reg              <= 6'h00;
    end
    else
    begin
      instruction_pointer_reg   <= instruction_pointer_next;
      transfer_prefix_latch_reg <= transfer_prefix_latch_next;
      service_reg               <= service_next;
      data_pointer_reg          <= data_pointer_next;
      conflict_reg              <= conflict_next;
      pop_data_reg              <= pop_data_next;
      if (exec_instr)
      begin
        last_word_reg   <= iw;
        xfer_val_reg    <= xfer_val;
        xfer_stored_reg <= slot_we || special_wr || dm_we;             // RULE9
      end
      if (wr_en && (paddr == `CRT_ADDR_PEEK))
        peek_sel_reg <= pwdata[5:0];
    end
  end

  // Working SRAM keeps contents through reset
  always @(posedge pclk)
  begin
    if (dm_we)
      dmem[data_pointer_reg[3:0]] <= xfer_val;                         // RULE13
  end

  // Read data, captured in the setup phase
  always @*
  begin
    case (paddr)
      `CRT_ADDR_INSTR: rd_mux = {16'h0000, last_word_reg};
      `CRT_ADDR_STKOP: rd_mux = {16'h0000, pop_data_reg};
      `CRT_ADDR_STAT:  rd_mux = {8'h00, transfer_prefix_latch_reg, 6'h00,
                                 conflict_reg, service_reg, 3'h0, stk_ptr};
      `CRT_ADDR_IPTR:  rd_mux = {16'h0000, instruction_pointer_reg};
      `CRT_ADDR_DPTR:  rd_mux = {16'h0000, data_pointer_reg};
      `CRT_ADDR_XFER:  rd_mux = {15'h0000, xfer_stored_reg, xfer_val_reg};
      `CRT_ADDR_PEEK:  rd_mux = {10'h000, peek_sel_reg, slot_q[peek_sel_reg]}; // RULE19
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

  assign fetch_addr                = instruction_pointer_reg;          // RULE21
  assign interrupt_in_service_flag = service_reg;

endmodule // crt_core

/* hdl/crt_map.vh */
`ifndef CRT_MAP_VH
`define CRT_MAP_VH
// What this block does
// RULE1: Index 0h-7h read or written in one cycle
// RULE2: Index 8h-0Fh: one-cycle read, prefixed two-cycle write
// RULE3: Peripheral index 10h-1Fh always needs prefix
// RULE4: System module 16 slots, peripheral module 32
// RULE5: 8-to-16 move: high byte from prefix latch
// RULE6: 16-to-8 move keeps only source low byte
// RULE7: Equal-width moves copy all bits unchanged
// RULE8: Prefix latch clears after the following instruction
// RULE9: Undefined destination stores nothing, source effects stay
// RULE10: Undefined read, byte module: prefix high, 00h low
// RULE11: Undefined read, word-only module returns 0000h
// RULE12: Any reset starts fetch at 8000h
// RULE13: Working SRAM untouched by reset
// RULE14: 16-bit 32-entry return stack for calls, pushes
// RULE15: Pop-and-clear pops and clears in-service flag
// RULE16: Reset loads stack pointer with 1Fh
// RULE17: Push-type operations increment pointer, then write
// RULE18: Pop-type operations read entry, then decrement
// RULE19: Stack reachable only through stack operations; moves from or to system index 2h also pop or push it
// RULE20: Pointer write redirects fetch next cycle
// RULE21: Pointer advances one word per fetch
// RULE22: Segment never program and data at once
// RULE23: Prefix supplies index bits and immediate high byte
// RULE24: Stack pointer wraps modulo 32
`define CRT_ADDR_INSTR   8'h00
`define CRT_ADDR_STKOP   8'h04
`define CRT_ADDR_STAT    8'h08
`define CRT_ADDR_IPTR    8'h0C
`define CRT_ADDR_DPTR    8'h10
`define CRT_ADDR_XFER    8'h14
`define CRT_ADDR_PEEK    8'h18
`define CRT_IPTR_RST     16'h8000
`define CRT_STK_RST      5'h1F
`define CRT_MOD_PER      4'h0
`define CRT_MOD_SYS      4'h8
`define CRT_MOD_ACC      4'h9
`define CRT_IDX_IPTR     4'h0
`define CRT_IDX_STKPTR   4'h1
`define CRT_IDX_STK      4'h2
`define CRT_IDX_PREFIX   4'h3
`define CRT_IDX_SERVICE  4'h4
`define CRT_IDX_DPTR     4'h5
`define CRT_IDX_DMEM     4'h6
`define CRT_IDX_HOLE     4'h7
`define CRT_UNDEF_LOW    8'h00
`define CRT_UNDEF_WORD   16'h0000
`define CRT_OP_CALL      3'h1
`define CRT_OP_RET       3'h2
`define CRT_OP_RET_INT   3'h3
`define CRT_OP_PUSH      3'h4
`define CRT_OP_POP       3'h5
`define CRT_OP_POP_CLR   3'h6
`define CRT_OP_INT       3'h7
`define CRT_ST_SERVICE   8
`define CRT_ST_CONFLICT  9
`define CRT_SRAM_SEG     5'h14
`define CRT_DMEM_WORDS   16
`endif

/* hdl/crt_width.v */
`timescale 1ns/10ps
module crt_width (
  input  wire [15:0] src_val,
  input  wire        src_wide,
  input  wire        dst_wide,
  input  wire [7:0]  prefix,
  output wire [15:0] dst_val
);

  // Width conversion of one register move
  assign dst_val = dst_wide ? (src_wide ? src_val                      // RULE7
                                        : {prefix, src_val[7:0]})      // RULE5
                            : {8'h00, src_val[7:0]};                   // RULE6

endmodule // crt_width

/* hdl/crt_stack.v */
`timescale 1ns/10ps
`include "crt_map.vh"
module crt_stack (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        push,
  input  wire        pop,
  input  wire [15:0] wdata,
  output wire [15:0] rdata,
  output wire [4:0]  stack_pointer
);

  reg  [4:0]  stack_pointer_reg;
  reg  [15:0] entry [0:31];
  wire [4:0]  up_idx;

  assign up_idx        = stack_pointer_reg + 5'h01;                     // RULE24
  assign rdata         = entry[stack_pointer_reg];                     // RULE18
  assign stack_pointer = stack_pointer_reg;

  // Pointer only; entries have no reset
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stack_pointer_reg <= `CRT_STK_RST;                               // RULE16
    else if (push)
      stack_pointer_reg <= up_idx;                                     // RULE17
    else if (pop)
      stack_pointer_reg <= stack_pointer_reg - 5'h01;                  // RULE18 RULE24
  end

  always @(posedge pclk)
  begin
    if (push)
      entry[up_idx] <= wdata;                                          // RULE17 RULE14
  end

endmodule // crt_stack

/* tb/crt_core_monitor.sv */
`timescale 1ns/10ps
module crt_core_monitor (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [15:0] fetch_addr,
  input wire        interrupt_in_service_flag
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Decoded bus events
  wire acc    = psel && penable;
  wire wr_acc = acc && pwrite;
  wire mapped = (paddr <= 8'h18) && (paddr[1:0] == 2'h0);
  wire ip_dst = (pwdata[11:8] == 4'h8) && (pwdata[14:12] == 3'h0);
  wire stk_wr = wr_acc && (paddr == 8'h04);
  wire ins_wr = wr_acc && (paddr == 8'h00);
  wire [2:0] op = pwdata[2:0];

  zero_wait_a: assert property (acc |-> pready)
    else $error("access phase without ready");
  unmapped_err_a: assert property (acc && !mapped |-> pslverr)
    else $error("unmapped access without error");
  mapped_ok_a: assert property (!acc || mapped |-> !pslverr)
    else $error("error flag on legal access");
  reset_fetch_a: assert property ($rose(presetn) |-> fetch_addr == 16'h8000)
    else $error("fetch not at boot entry");
  fetch_step_a: assert property (ins_wr && !ip_dst |=>
    fetch_addr == $past(fetch_addr) + 16'h0001)
    else $error("fetch did not advance by one");
  stack_step_a: assert property (stk_wr && op >= 3'h4 && op <= 3'h6 |=>
    fetch_addr == $past(fetch_addr) + 16'h0001)
    else $error("stack op did not advance fetch");
  call_jump_a: assert property (stk_wr && (op == 3'h1 || op == 3'h7) |=>
    fetch_addr == $past(pwdata[31:16]))
    else $error("fetch not redirected");
  int_entry_a: assert property (stk_wr && op == 3'h7 |=> interrupt_in_service_flag)
    else $error("service flag not set");
  pop_clear_a: assert property (stk_wr && op == 3'h6 |=> !interrupt_in_service_flag)
    else $error("service flag not cleared");
  idle_hold_a: assert property (!wr_acc |=>
    $stable(fetch_addr) && $stable(interrupt_in_service_flag))
    else $error("state moved without a write");

  cover property (stk_wr && op == 3'h7);
  cover property (acc && !mapped);
  cover property (ins_wr && ip_dst);
endmodule // crt_core_monitor

/* tb/core_register_transfer_stack_tb_top.sv */
`timescale 1ns/10ps
module core_register_transfer_stack_tb_top;
  reg         pclk;
  reg         presetn;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire [15:0] fetch_addr;
  wire        interrupt_in_service_flag;
  integer     mismatches;
  integer     checks_done;
  integer     sp;
  integer     ip;
  integer     i;
  reg  [15:0] lfsr;
  reg  [15:0] stk [0:31];
  reg  [31:0] rd;
  reg         err;
  reg  [7:0]  pf;
  reg  [7:0]  b;

  crt_core DUT (
    .pclk                      (pclk),
    .presetn                   (presetn),
    .psel                      (psel),
    .penable                   (penable),
    .pwrite                    (pwrite),
    .paddr                     (paddr),
    .pwdata                    (pwdata),
    .prdata                    (prdata),
    .pready                    (pready),
    .pslverr                   (pslverr),
    .fetch_addr                (fetch_addr),
    .interrupt_in_service_flag (interrupt_in_service_flag)
  );

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  function [15:0] rnd(input [15:0] s);
    rnd = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task end_sim;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e)
      begin
        mismatches = mismatches + 1;
        $display("mismatch %s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  // One APB transfer, then one idle cycle
  task xfer(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      n = 0;
      while (pready !== 1'b1)
      begin
        n = n + 1;
        if (n > 20)
        begin
          mismatches = mismatches + 1;
          end_sim;
        end
        @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task rdchk(input [7:0] a, input string nm, input [31:0] e);
    begin
      xfer(1'b0, a, 32'h0);
      chk(nm, e, rd);
    end
  endtask

  task mv(input [7:0] p, input [15:0] iw);
    begin
      if (p != 8'h00)
        xfer(1'b1, 8'h00, {24'h0, 8'h38} << 8 | p);
      xfer(1'b1, 8'h00, {16'h0, iw});
    end
  endtask

  task peek(input [5:0] ix, input [15:0] e);
    begin
      xfer(1'b1, 8'h18, {26'h0, ix});
      rdchk(8'h18, "slot", {10'h0, ix, e});
    end
  endtask

  task do_reset;
    begin
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      sp = 31;
      ip = 32'h8000;
    end
  endtask

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    mismatches = 0;
    checks_done = 0;
    lfsr = 16'h3474;
    do_reset;
    rdchk(8'h0C, "iptr", 32'h8000);
    rdchk(8'h08, "stat", 32'h1F);
    for (i = 0; i < 33; i = i + 1)
    begin
      lfsr = rnd(lfsr);
      xfer(1'b1, 8'h04, {lfsr, 16'h0004});
      sp = (sp + 1) % 32;
      stk[sp] = lfsr;
      ip = ip + 1;
    end
    rdchk(8'h08, "sp", sp);
    for (i = 0; i < 32; i = i + 1)
    begin
      xfer(1'b1, 8'h04, 32'h5);
      rdchk(8'h04, "pop", {16'h0, stk[sp]});
      sp = (sp + 31) % 32;
      ip = ip + 1;
    end
    rdchk(8'h0C, "iptr", ip);
    xfer(1'b1, 8'h04, 32'h12340001);
    chk("fetch", 32'h1234, {16'h0, fetch_addr});
    xfer(1'b1, 8'h04, 32'h00400007);
    chk("svc", 32'h1, {31'h0, interrupt_in_service_flag});
    xfer(1'b1, 8'h04, 32'h3);
    chk("fetch", 32'h1234, {16'h0, fetch_addr});
    xfer(1'b1, 8'h04, 32'h6);
    rdchk(8'h04, "pop", ip + 1);
    chk("svc", 32'h0, {31'h0, interrupt_in_service_flag});
    lfsr = rnd(lfsr);
    pf = {lfsr[15], 2'b00, lfsr[12:8]};
    b = lfsr[7:0];
    mv(pf, {8'h20, b});
    mv(8'h00, {8'h10, ~b});
    peek(6'd2, {pf, b});
    peek(6'd1, {8'h00, ~b});
    mv(8'h40, 16'h8020);
    peek(6'd16, {8'h00, b});
    mv(8'h50, 16'h9000);
    peek(6'd17, {8'h00, b});
    mv(8'h10, 16'hA000);
    peek(6'd2, {8'h10, b});
    mv(8'h0A, 16'hD020);
    peek(6'd5, {8'h10, b});
    mv(8'h0A, 16'hB078);
    peek(6'd3, 16'h0A00);
    mv(8'h0A, 16'hC0F9);
    peek(6'd4, 16'h0000);
    mv(8'h60, {8'h70, ~b});
    peek(6'd31, {8'h00, ~b});
    mv(8'h20, 16'hB820);
    peek(6'd43, {8'h10, b});
    mv(8'h00, 16'h80B8);
    peek(6'd0, {8'h10, b});
    mv(8'h12, 16'h0834);
    chk("fetch", 32'h1234, {16'h0, fetch_addr});
    mv(8'h00, 16'h5803);
    mv(8'h00, 16'hE820);
    do_reset;
    chk("fetch", 32'h8000, {16'h0, fetch_addr});
    mv(8'h00, 16'h5803);
    mv(8'h00, 16'hE068);
    peek(6'd6, {8'h10, b});
    rdchk(8'h10, "dptr", 32'h2);
    mv(8'h00, 16'h5803);
    mv(8'h00, 16'h8768);
    rdchk(8'h10, "dptr", 32'h2);
    rdchk(8'h14, "xfer", {15'h0, 1'b0, 8'h00, b});
    chk("stored", 32'h0, {31'h0, rd[16]});
    xfer(1'b1, 8'h04, 32'hA0000001);
    mv(8'h00, 16'hE820);
    rdchk(8'h14, "xfer", 32'h0);
    xfer(1'b0, 8'h08, 32'h0);
    chk("conflict", 32'h1, {31'h0, rd[9]});
    xfer(1'b1, 8'h08, 32'h200);
    xfer(1'b0, 8'h08, 32'h0);
    chk("conflict", 32'h0, {31'h0, rd[9]});
    xfer(1'b0, 8'h40, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    chk("prdata", 32'h0, rd);
    end_sim;
  end
endmodule // core_register_transfer_stack_tb_top

bind crt_core crt_core_monitor u_mon (
  .pclk                      (pclk),
  .presetn                   (presetn),
  .psel                      (psel),
  .penable                   (penable),
  .pwrite                    (pwrite),
  .paddr                     (paddr),
  .pwdata                    (pwdata),
  .prdata                    (prdata),
  .pready                    (pready),
  .pslverr                   (pslverr),
  .fetch_addr                (fetch_addr),
  .interrupt_in_service_flag (interrupt_in_service_flag)
);
